// ==== rtl/quad_line_host_port.sv ====
// Purpose: host control port of a four channel line transceiver
// Assumes: all host pins asynchronous; sampled by clk after two flops
// Notes:   register store is outside; read data arrives one clk later
module quad_line_host_port
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  // strap and control pins
  input  wire host_port_pkg::strap_t                 straps,
  input  wire host_port_pkg::ctl_pins_t              ctl,
  // shared address/data pins, three signal form
  input  wire logic [host_port_pkg::DATA_W-1:0]      addr_data_in,
  output logic      [host_port_pkg::DATA_W-1:0]      addr_data_out,
  output logic      [host_port_pkg::DATA_W-1:0]      addr_data_oe,
  // interrupt pin, open drain
  output logic                                       int_out,
  output logic                                       int_oe,
  // register access towards the transceivers
  output host_port_pkg::reg_req_t                    req,
  input  wire logic [host_port_pkg::DATA_W-1:0]      rdata,
  // pending enabled events from the status registers
  input  wire logic [host_port_pkg::NUM_XCVR-1:0]    event_pending
);

  localparam int SW = $bits(strap_t) + $bits(ctl_pins_t) + DATA_W;

  strap_t            st;
  ctl_pins_t         cp;
  logic [DATA_W-1:0] bus_s;
  logic [SW-1:0]     sync_v;

  // every pin passes two flops before use
  pin_sync #(.W(SW)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({straps, ctl, addr_data_in}),
    .sync_out (sync_v)
  );
  assign {st, cp, bus_s} = sync_v;

  function automatic port_mode_t decode_mode(input logic hi, input logic lo);
    return port_mode_t'({hi, lo});
  endfunction

  port_mode_t mode;
  logic       cs_act, cs_prev_q, style_ds;
  logic       rd_act, wr_act, as_prev_q, dstb_prev_q;
  logic [1:0] xcvr;

  assign mode     = decode_mode(st.bus_sel_hi, st.bus_sel_lo);
  assign style_ds = st.bus_style_sel;
  assign xcvr     = {st.xcvr_sel_hi, st.xcvr_sel_lo};
  assign cs_act   = !cp.chip_sel_n;

  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (!style_ds) begin
      rd_act = !cp.rd_strobe;
      wr_act = !cp.wr_strobe;
    end else if (mode == MODE_MUX) begin
      rd_act = cp.rd_strobe && cp.wr_strobe;
      wr_act = cp.rd_strobe && !cp.wr_strobe;
    end else begin
      rd_act = !cp.rd_strobe && cp.wr_strobe;
      wr_act = !cp.rd_strobe && !cp.wr_strobe;
    end
  end

  logic              par_mode;
  logic [ADDR_W-1:0] mux_addr_q, par_addr;
  logic              wr_prev_q;
  assign par_mode = (mode == MODE_MUX) || (mode == MODE_NONMUX);

  // latch address on rising address strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mux_addr_q <= ADDR_RST;
      as_prev_q  <= 1'b0;
    end else begin
      as_prev_q <= cp.addr_strobe;
      if (mode == MODE_MUX && cs_act && cp.addr_strobe && !as_prev_q)
        mux_addr_q <= bus_s[ADDR_W-1:0];
    end
  end

  // nonmuxed address from pins; muxed from latch
  assign par_addr = (mode == MODE_NONMUX) ?
                    {cp.addr_strobe, cp.low_addr_bus} : mux_addr_q;

  // serial engine state
  ser_state_t        ser_q;
  logic [2:0]        bit_q;
  logic [DATA_W-1:0] sh_q;
  logic [ADDR_W-1:0] ser_addr_q;
  logic              burst_q, sclk_prev_q, sout_q;
  logic              s_rise, s_fall, s_sample, s_drive;
  logic              ser_on;

  assign ser_on = (mode == MODE_SERIAL) && cs_act;
  assign s_rise = cp.rd_strobe && !sclk_prev_q;
  assign s_fall = !cp.rd_strobe && sclk_prev_q;
  assign s_sample = st.in_edge_sel ? s_fall : s_rise;
  assign s_drive  = st.out_edge_sel ? s_rise : s_fall;

  logic              ser_wr_p, ser_rd_p;
  logic [DATA_W-1:0] shifted;
  assign shifted = {cp.wr_strobe, sh_q[DATA_W-1:1]};

  // serial receive and command handling
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ser_q       <= SER_IDLE;
      bit_q       <= 3'h0;
      sh_q        <= DATA_RST;
      ser_addr_q  <= ADDR_RST;
      burst_q     <= 1'b0;
      sclk_prev_q <= 1'b0;
      ser_wr_p    <= 1'b0;
      ser_rd_p    <= 1'b0;
    end else begin
      sclk_prev_q <= cp.rd_strobe;
      ser_wr_p    <= 1'b0;
      ser_rd_p    <= 1'b0;
      if (!ser_on) begin
        ser_q <= SER_IDLE;
        bit_q <= 3'h0;
      end else begin
        if (ser_q == SER_IDLE)
          ser_q <= SER_CMD;
        if (s_sample && ser_q != SER_RDAT) begin
          sh_q  <= shifted;
          bit_q <= bit_q + 3'h1;
          if (bit_q == BIT_LAST) begin
            if (ser_q != SER_WDAT) begin
              ser_addr_q <= shifted[CMD_ADDR_LSB +: 5] & 6'h1f;
              burst_q    <= shifted[CMD_BURST_BIT];
              ser_q      <= shifted[CMD_RD_BIT] ? SER_RDAT : SER_WDAT;
              ser_rd_p   <= shifted[CMD_RD_BIT];
            end else begin
              ser_wr_p <= 1'b1;
            end
          end
        end else if (s_sample && ser_q == SER_RDAT) begin
          bit_q <= bit_q + 3'h1;
          if (bit_q == BIT_LAST) begin
            if (burst_q) begin
              ser_addr_q <= ser_addr_q + 6'h01;
              ser_rd_p   <= 1'b1;
            end else begin
              ser_q <= SER_IDLE;
            end
          end
        end
        if (ser_wr_p && burst_q)
          ser_addr_q <= ser_addr_q + 6'h01;
      end
    end
  end

  // serial output shifter, loads read data after each fetch
  // fetch pulse, then the read request, then rdata one cycle after it:
  // loading any earlier would shift out the previous read's data
  logic [DATA_W-1:0] out_sh_q;
  logic              load_q;
  logic              load2_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_sh_q <= DATA_RST;
      sout_q   <= 1'b0;
      load_q   <= 1'b0;
      load2_q  <= 1'b0;
    end else begin
      load_q  <= ser_rd_p;   // request goes out this cycle
      load2_q <= load_q;     // rdata stands from here on
      if (!ser_on) begin
        sout_q <= 1'b0;
      end else if (load2_q) begin
        out_sh_q <= rdata;
      end else if (s_drive && ser_q == SER_RDAT) begin
        // bit held until next driving edge
        sout_q   <= out_sh_q[0];
        out_sh_q <= {1'b0, out_sh_q[DATA_W-1:1]};
      end
    end
  end

  // parallel write capture and request generation
  logic wr_edge, rd_edge, rd_prev_q;
  assign wr_edge = par_mode && cs_act && !wr_act && wr_prev_q;
  assign rd_edge = par_mode && cs_act && rd_act && !rd_prev_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_prev_q   <= 1'b0;
      rd_prev_q   <= 1'b0;
      dstb_prev_q <= 1'b0;
      req         <= '0;
    end else begin
      wr_prev_q   <= par_mode && cs_act && wr_act;
      rd_prev_q   <= rd_act;
      dstb_prev_q <= cp.rd_strobe;
      req.write   <= 1'b0;
      req.read    <= 1'b0;
      req.xcvr    <= xcvr;
      if (wr_edge) begin
        req.write <= 1'b1;
        req.addr  <= par_addr;
        req.wdata <= bus_s;
      end else if (rd_edge) begin
        req.read <= 1'b1;
        req.addr <= par_addr;
      end else if (ser_wr_p) begin
        req.write <= 1'b1;
        req.addr  <= ser_addr_q;
        req.wdata <= sh_q;
      end else if (ser_rd_p) begin
        req.read <= 1'b1;
        req.addr <= ser_addr_q;
      end
    end
  end

  // bus drive and serial output tri-state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_data_out <= DATA_RST;
      addr_data_oe  <= DATA_RST;
    end else if (par_mode && cs_act && rd_act) begin
      addr_data_out <= rdata;
      addr_data_oe  <= 8'hff;
    end else if (ser_on) begin
      // serial output stays driven while selected, so the last data bit
      // is held after the read phase ends on its own sampling edge
      addr_data_out <= {sout_q, 7'h00};
      addr_data_oe  <= 8'h80;
    end else begin
      addr_data_out <= DATA_RST;
      addr_data_oe  <= DATA_RST;
    end
  end

  // open drain interrupt, hi-z in test mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_out <= 1'b0;
      int_oe  <= 1'b0;
    end else begin
      int_out <= 1'b0;
      int_oe  <= (|event_pending) && (mode != MODE_HIZ);
    end
  end

endmodule

// ==== rtl/host_port_pkg.sv ====
// Purpose: shared constants and types for the quad line host port
// Assumes: 125 MHz core clock, all host pins asynchronous to it
// Notes:   pin bundles travel as packed structs
package host_port_pkg;

  // bus select codes {bus_sel_hi, bus_sel_lo}
  localparam logic [1:0] SEL_MUX    = 2'h0;
  localparam logic [1:0] SEL_NONMUX = 2'h1;
  localparam logic [1:0] SEL_SERIAL = 2'h2;
  localparam logic [1:0] SEL_HIZ    = 2'h3;

  // serial command byte fields, lsb first on the wire
  localparam int CMD_RD_BIT    = 0;
  localparam int CMD_ADDR_LSB  = 1;
  localparam int CMD_BURST_BIT = 7;
  localparam int ADDR_W        = 6;
  localparam int DATA_W        = 8;
  localparam int NUM_XCVR      = 4;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;

  typedef enum logic [1:0] {
    MODE_MUX    = 2'b00,
    MODE_NONMUX = 2'b01,
    MODE_SERIAL = 2'b10,
    MODE_HIZ    = 2'b11
  } port_mode_t;

  // serial engine phases
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_CMD  = 2'b01,
    SER_WDAT = 2'b10,
    SER_RDAT = 2'b11
  } ser_state_t;

  // strap pins
  typedef struct packed {
    logic bus_sel_hi;
    logic bus_sel_lo;
    logic bus_style_sel;
    logic xcvr_sel_hi;
    logic xcvr_sel_lo;
    logic in_edge_sel;
    logic out_edge_sel;
  } strap_t;

  // parallel and serial control pins
  typedef struct packed {
    logic       chip_sel_n;
    logic       rd_strobe;     // read strobe, data strobe or serial clock
    logic       wr_strobe;     // write strobe, direction or serial input
    logic       addr_strobe;   // latch strobe or top_addr_bit
    logic [4:0] low_addr_bus;
  } ctl_pins_t;

  // register access towards the transceivers
  typedef struct packed {
    logic                write;
    logic                read;
    logic [1:0]          xcvr;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } reg_req_t;

endpackage

// ==== rtl/pin_sync.sv ====
// Purpose: two flop synchroniser for a vector of asynchronous pins
// Assumes: pins are quasi static or slower than clk
// Notes:   first stage is read only by the second stage
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // pins in and synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // two stage capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== bench/host_port_properties.sv ====
// Purpose: port checker for the quad line host port
// Assumes: sync flops give a few clk of latency on every pin
// Notes:   attached by bind below the module
module host_port_properties
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic                      clk,
  input wire logic                      reset_n,
  // pins
  input wire host_port_pkg::strap_t     straps,
  input wire host_port_pkg::ctl_pins_t  ctl,
  input wire logic [DATA_W-1:0]         addr_data_oe,
  input wire logic                      int_out,
  input wire logic                      int_oe,
  // register side
  input wire host_port_pkg::reg_req_t   req,
  input wire logic [NUM_XCVR-1:0]       event_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // held conditions that outputs must follow
  sequence cs_idle; ctl.chip_sel_n [*6]; endsequence
  sequence hiz_held; (straps.bus_sel_hi && straps.bus_sel_lo) [*6];
  endsequence
  sequence ser_held; (straps.bus_sel_hi && !straps.bus_sel_lo) [*6];
  endsequence
  sequence ev_held;
    (|event_pending && !(straps.bus_sel_hi && straps.bus_sel_lo)) [*6];
  endsequence
  a_cs_quiet: assert property (cs_idle |-> !req.write && !req.read
    && addr_data_oe == '0) else $error("activity while deselected");
  a_hiz_nodrive: assert property (hiz_held |-> addr_data_oe == '0
    && !int_oe) else $error("drive in high-z mode");
  a_ser_onepin: assert property (ser_held |-> addr_data_oe[6:0] == '0)
    else $error("serial mode drives data pins");
  a_int_set: assert property (ev_held |-> int_oe)
    else $error("pending event not flagged");
  a_int_clear: assert property (!(|event_pending) [*6] |-> !int_oe)
    else $error("flag without pending event");
  a_int_pulldown: assert property (int_out == 1'b0)
    else $error("interrupt drives high");
  a_req_excl: assert property (!(req.write && req.read))
    else $error("read and write together");
  a_req_pulse: assert property (req.write |=> !req.write)
    else $error("write request longer than one cycle");
  a_xcvr_route: assert property ((req.write || req.read) |->
    req.xcvr == {straps.xcvr_sel_hi, straps.xcvr_sel_lo})
    else $error("wrong transceiver");
endmodule
bind quad_line_host_port host_port_properties i_props (.clk, .reset_n,
  .straps, .ctl, .addr_data_oe, .int_out, .int_oe, .req, .event_pending);

// ==== bench/host_model.sv ====
// Purpose: behavioural host driving parallel and serial pins
// Assumes: strobes held several clk; serial clock 125 ns in frames
// Notes:   a released bus shows the inverse of the last host value
module host_model
  import host_port_pkg::*;
(
  // clock and straps
  input wire logic                   clk,
  input wire host_port_pkg::strap_t  straps,
  // device bus outputs
  input wire logic [7:0]             dout,
  input wire logic [7:0]             doe,
  // host driven pins
  output host_port_pkg::ctl_pins_t   ctl,
  output logic [7:0]                 din
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] hdat;
  logic       hoe;
  initial begin
    ctl = '{1'b1, 1'b1, 1'b1, 1'b0, 5'h00};
    hdat = 8'h00;
    hoe = 1'b0;
  end
  // wire level from both drivers
  always_comb
    for (int i = 0; i < 8; i++)
      din[i] = doe[i] ? dout[i] : (hoe ? hdat[i] : ~hdat[i]);
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // parallel access in the mode given by the straps
  task automatic par(input bit rd, input logic [5:0] a,
                     input logic [7:0] wd, output logic [7:0] rv);
    logic mux, sty, act;
    mux = !straps.bus_sel_lo;
    sty = straps.bus_style_sel;
    act = sty & mux;
    ctl.rd_strobe <= !act;
    ctl.wr_strobe <= sty ? rd : 1'b1;
    hold(6);
    ctl.chip_sel_n <= 1'b0;
    ctl.low_addr_bus <= mux ? 5'h00 : a[4:0];
    ctl.addr_strobe <= mux ? 1'b0 : a[5];
    hdat <= mux ? {2'h0, a} : wd;
    hoe <= mux | !rd;
    hold(6);
    if (mux) begin
      ctl.addr_strobe <= 1'b1;
      hold(6);
      ctl.addr_strobe <= 1'b0;
      hdat <= wd;
      hoe <= !rd;
      hold(4);
    end
    if (sty) ctl.rd_strobe <= act;
    else if (rd) ctl.rd_strobe <= 1'b0;
    else ctl.wr_strobe <= 1'b0;
    hold(12);
    rv = din;
    ctl.rd_strobe <= !act;
    ctl.wr_strobe <= 1'b1;
    hold(6);
    ctl.chip_sel_n <= 1'b1;
    hoe <= 1'b0;
    hold(6);
  endtask
  // serial frame, command byte then one data byte, lsb first
  task automatic ser(input logic [7:0] cmd, input logic [7:0] wd,
                     output logic [7:0] rv);
    logic [16:0] sh;
    int          off;
    sh = {1'b0, wd, cmd};
    // sampling and driving both on falling edges puts the first data bit
    // on the falling edge after the command, so that frame takes one
    // more clock and each bit is read on the rising edge that follows
    off = (straps.in_edge_sel && !straps.out_edge_sel) ? 9 : 8;
    ctl.rd_strobe <= 1'b0;
    hold(4);
    ctl.chip_sel_n <= 1'b0;
    hold(4);
    for (int i = 0; i < off + 8; i++) begin
      // host acts opposite the device edges
      if (!straps.in_edge_sel) ctl.wr_strobe = sh[i];
      #62.5 ctl.rd_strobe = 1'b1;
      if (straps.in_edge_sel) ctl.wr_strobe = sh[i];
      if (i >= off && !straps.out_edge_sel) rv[i-off] = din[7];
      #62.5;
      if (i >= off && straps.out_edge_sel) rv[i-off] = din[7];
      ctl.rd_strobe = 1'b0;
    end
    hold(4);
    ctl.chip_sel_n <= 1'b1;
    hold(4);
  endtask
endmodule

// ==== bench/testbench.sv ====
// Purpose: self checking bench for the quad line host port
// Assumes: register store modelled here, answers a cycle after a read
// Notes:   random addresses and data from a fixed seed
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import host_port_pkg::*;
  logic       clk, reset_n, int_out, int_oe;
  strap_t     straps;
  ctl_pins_t  ctl;
  logic [7:0] din, dout, doe, rdata;
  reg_req_t   req, wq, rq;
  logic [3:0] event_pending;
  int         err_count, samples_checked, cycles;
  logic [7:0] mem [256];
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  quad_line_host_port i_dut (.clk(clk), .reset_n(reset_n),
    .straps(straps), .ctl(ctl), .addr_data_in(din), .addr_data_out(dout),
    .addr_data_oe(doe), .int_out(int_out), .int_oe(int_oe), .req(req),
    .rdata(rdata), .event_pending(event_pending));
  host_model i_host (.clk(clk), .straps(straps), .dout(dout), .doe(doe),
    .ctl(ctl), .din(din));
  // register store, request capture and run limit
  always @(posedge clk) begin
    if (req.read) rdata <= mem[{req.xcvr, req.addr}];
    if (req.write) wq <= req;
    if (req.read) rq <= req;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk_req(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic mode(input logic [6:0] s);
    @(posedge clk);
    straps <= s;
    repeat (6) @(posedge clk);
  endtask
  // one access through the host, checked against the model
  task automatic acc(input bit rd, input bit ser);
    logic [1:0] x;
    logic [5:0] a;
    logic [7:0] d, v;
    x = $urandom;
    a = $urandom;
    d = $urandom;
    if (ser) a[5] = 1'b0;
    wq = '0;
    rq = '0;
    @(posedge clk);
    straps.xcvr_sel_hi <= x[1];
    straps.xcvr_sel_lo <= x[0];
    repeat (6) @(posedge clk);
    if (ser) i_host.ser({2'h0, a[4:0], rd}, d, v);
    else i_host.par(rd, a, d, v);
    if (rd) begin
      chk_req({rq.read, rq.xcvr, rq.addr, 8'h00}, {1'b1, x, a, 8'h00});
      chk_val(v, mem[{x, a}]);
    end else begin
      chk_req({wq.write, wq.xcvr, wq.addr, wq.wdata}, {1'b1, x, a, d});
      mem[{x, a}] = d;
    end
  endtask
  initial begin
    reset_n = 1'b0;
    straps = '0;
    event_pending = 4'h0;
    rdata = 8'h00;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(16524));
    for (int i = 0; i < 256; i++) mem[i] = $urandom;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      mode({1'b0, m[0], m[1], 4'h0});
      repeat (2) begin
        acc(0, 0);
        acc(1, 0);
      end
    end
    for (int m = 0; m < 4; m++) begin
      mode({2'h2, 3'h0, m[1:0]});
      acc(0, 1);
      acc(1, 1);
    end
    event_pending <= 4'h1 << $urandom_range(3);
    repeat (8) @(posedge clk);
    chk_val({7'h0, int_oe}, 8'h01);
    chk_val({7'h0, int_out}, 8'h00);
    mode(7'h60);
    chk_val({7'h0, int_oe}, 8'h00);
    chk_val(doe, 8'h00);
    mode(7'h40);
    event_pending <= 4'h0;
    repeat (8) @(posedge clk);
    chk_val({7'h0, int_oe}, 8'h00);
    report_and_stop();
  end
endmodule
